/* File: src/vlan_rd_defs.vh */
// constants for the vlan table read-data block
// assumes a 32-bit register port indexed by 16-bit register numbers
`ifndef VLAN_RD_DEFS_VH
`define VLAN_RD_DEFS_VH
`define REG_VLAN_CMD        16'h180b
`define REG_VLAN_WR_DATA    16'h180c
`define REG_VLAN_RD_DATA    16'h180e
`define REG_VLAN_CMD_STS    16'h1810
`define REG_ADMIT_NONMEM    16'h1880
`define REG_EGRESS_TYPE     16'h1881
`define CMD_RNW_BIT         5
`define CMD_PVID_BIT        4
`define ENTRY_W             18
`define VID_W               12
`define RD_DATA_RST         18'h00000
`define EGRESS_HYBRID       2'h3
`define OP_CYCLES           3'h3
`define VLAN_ENTRIES        16
`define NUM_PORTS           3
`endif

/* File: src/vlan_table_read_data.v */
// vlan and port-vid table store with command, status and read-data registers,
// plus per-port ingress/egress decisions for one lookup vid.
// assumes one synchronous register port; data ready on the cycle after a read strobe.
// assumes the host polls the pending bit before it reads the entry back, and
// that lookup_vid_in is held for one clock before the port decisions are used.
//
// What this block does
// - read-only 18-bit read data, upper bits zero
// - vlan table select returns vlan entry format
// - member bits 17/15/13 admit and join broadcast
// - non-member drops unless admit-nonmember and the vid hits an entry, excluded egress
// - untag bits 16/14/12 strip on hybrid ports
// - vid in bits 11:0, zero disables entry
// - command read_not_write bit one means read
// - table select one is pvid, index 3:0
// - pending set during command, cleared on completion
`timescale 1ns/1ps
`include "vlan_rd_defs.vh"
module vlan_table_read_data (
    // clock and reset
    input  wire        mclk_in,
    input  wire        sys_rst_in,
    // register port
    input  wire [15:0] reg_addr_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire [31:0] reg_wdata_in,
    output reg  [31:0] reg_rdata_out,
    // lookup side
    input  wire [11:0] lookup_vid_in,
    output reg  [2:0]  ingress_admit_out,
    output reg  [2:0]  egress_member_out,
    output reg  [2:0]  egress_untag_out
);
    // sequencer states
    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    // table storage, command copy and configuration
    reg [`ENTRY_W-1:0] vlan_mem_r [0:`VLAN_ENTRIES-1];
    reg [`VID_W-1:0]   pvid_mem_r [0:`NUM_PORTS-1];
    reg [5:0]          cmd_r;
    reg [`ENTRY_W-1:0] wr_data_r;
    reg [`ENTRY_W-1:0] vlan_table_read_data_r;
    reg                state_r;
    reg [2:0]          cnt_r;
    reg [2:0]          admit_nonmember_config_r;
    reg [5:0]          egress_port_type_config_r;
    reg [`ENTRY_W-1:0] rd_entry;
    reg [2:0]          hit_mem;
    reg [2:0]          hit_untag;
    reg                hit;
    // loop indices, one per process so neither is written from two places
    integer            i;
    integer            k;

    // address compare used by several decodes
    function is_reg;
        input [15:0] a;
        input [15:0] r;
        begin
            is_reg = (a == r);
        end
    endfunction

    wire cmd_wr = reg_wr_in && is_reg(reg_addr_in, `REG_VLAN_CMD);
    wire done   = (state_r == ST_BUSY) && (cnt_r == 3'h0);
    wire pvid_sel = cmd_r[`CMD_PVID_BIT];
    wire [3:0] idx = cmd_r[3:0];
    // only ports 0..2 exist in the pvid table; higher indexes are left alone
    wire pvid_ok = ({28'h0000000, idx} < `NUM_PORTS);

    // addressed entry; pvid index above port 2 returns zero
    always @*
    begin
        // default keeps the mux free of latches
        rd_entry = `RD_DATA_RST;
        if (pvid_sel)
        begin
            if (pvid_ok)
                rd_entry = {6'h00, pvid_mem_r[idx[1:0]]};
        end
        // vlan index covers all sixteen entries
        else
            rd_entry = vlan_mem_r[idx];
    end

    // config registers and command sequencer
    always @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            cmd_r <= 6'h00;
            wr_data_r <= `RD_DATA_RST;
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
            admit_nonmember_config_r <= 3'h0;
            egress_port_type_config_r <= 6'h00;
            vlan_table_read_data_r <= `RD_DATA_RST;
            for (i = 0; i < `VLAN_ENTRIES; i = i + 1)
                vlan_mem_r[i] <= `RD_DATA_RST;
            for (i = 0; i < `NUM_PORTS; i = i + 1)
                pvid_mem_r[i] <= 12'h000;
        end
        else
        begin
            // write data is staged here until a write command completes
            if (reg_wr_in && is_reg(reg_addr_in, `REG_VLAN_WR_DATA))
                wr_data_r <= reg_wdata_in[`ENTRY_W-1:0];
            // per-port ingress and egress settings, one or two bits per port
            if (reg_wr_in && is_reg(reg_addr_in, `REG_ADMIT_NONMEM))
                admit_nonmember_config_r <= reg_wdata_in[2:0];
            if (reg_wr_in && is_reg(reg_addr_in, `REG_EGRESS_TYPE))
                egress_port_type_config_r <= reg_wdata_in[5:0];
            // commands written while busy are ignored to keep the entry stable
            // busy lasts one clock more than OP_CYCLES while cnt_r counts down
            if (cmd_wr && state_r == ST_IDLE)
            begin
                cmd_r <= reg_wdata_in[5:0];
                state_r <= ST_BUSY;
                cnt_r <= `OP_CYCLES;
            end
            else if (state_r == ST_BUSY)
            begin
                // the entry moves in the same cycle the pending bit drops, so a
                // host that sees pending low always reads a complete entry
                if (done)
                begin
                    state_r <= ST_IDLE;
                    if (cmd_r[`CMD_RNW_BIT])
                        vlan_table_read_data_r <= rd_entry;
                    // write commands commit the staged data only at completion
                    else if (pvid_sel)
                    begin
                        if (pvid_ok)
                            pvid_mem_r[idx[1:0]] <= wr_data_r[`VID_W-1:0];
                    end
                    else
                        vlan_mem_r[idx] <= wr_data_r;
                end
                else
                    cnt_r <= cnt_r - 3'h1;
            end
        end
    end

    // per-port match over all vlan entries; vid zero never matches
    always @*
    begin
        hit_mem = 3'h0;
        hit_untag = 3'h0;
        hit = 1'b0;
        // several matching entries are merged by or, so duplicates widen access
        for (k = 0; k < `VLAN_ENTRIES; k = k + 1)
        begin
            if (vlan_mem_r[k][11:0] != 12'h000 &&
                vlan_mem_r[k][11:0] == lookup_vid_in)
            begin
                hit = 1'b1;
                hit_mem = hit_mem | {vlan_mem_r[k][17], vlan_mem_r[k][15],
                                     vlan_mem_r[k][13]};
                hit_untag = hit_untag | {vlan_mem_r[k][16], vlan_mem_r[k][14],
                                         vlan_mem_r[k][12]};
            end
        end
    end

    // registered port decisions, one generate slice per port
    // decisions are registered so the outputs come straight from flops
    // a port needs both the untag bit and the hybrid type to strip tags
    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1)
        begin : g_port
            always @(posedge mclk_in)
            begin
                if (sys_rst_in)
                begin
                    ingress_admit_out[p] <= 1'b0;
                    egress_member_out[p] <= 1'b0;
                    egress_untag_out[p] <= 1'b0;
                end
                else
                begin
                    ingress_admit_out[p] <= hit && (hit_mem[p] ||
                                            admit_nonmember_config_r[p]);
                    egress_member_out[p] <= hit && hit_mem[p];
                    egress_untag_out[p] <= hit && hit_untag[p] &&
                        egress_port_type_config_r[2*p+1 -: 2] == `EGRESS_HYBRID;
                end
            end
        end
    endgenerate

    // register read mux, unmapped reads return zero
    // reserved bits are padded with zeros at every address
    // read data and status have no write path: both stay read-only
    always @(posedge mclk_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= 32'h00000000;
        else if (reg_rd_in)
        begin
            if (is_reg(reg_addr_in, `REG_VLAN_RD_DATA))
                reg_rdata_out <= {14'h0000, vlan_table_read_data_r};
            else if (is_reg(reg_addr_in, `REG_VLAN_CMD_STS))
                reg_rdata_out <= {31'h00000000, state_r};
            else if (is_reg(reg_addr_in, `REG_VLAN_CMD))
                reg_rdata_out <= {26'h0000000, cmd_r};
            else if (is_reg(reg_addr_in, `REG_VLAN_WR_DATA))
                reg_rdata_out <= {14'h0000, wr_data_r};
            else if (is_reg(reg_addr_in, `REG_ADMIT_NONMEM))
                reg_rdata_out <= {29'h00000000, admit_nonmember_config_r};
            else if (is_reg(reg_addr_in, `REG_EGRESS_TYPE))
                reg_rdata_out <= {26'h0000000, egress_port_type_config_r};
            else
                reg_rdata_out <= 32'h00000000;
        end
    end
endmodule // vlan_table_read_data

/* File: tb/vlan_rd_monitor.sv */
// checker for the vlan read-data block, watching the top ports only
// assumes a bind from the bench top and a sync active-high reset
`timescale 1ns/1ps
module vlan_rd_monitor (
    input wire        mclk_in,
    input wire        sys_rst_in,
    input wire [15:0] reg_addr_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [31:0] reg_wdata_in,
    input wire [31:0] reg_rdata_out,
    input wire [11:0] lookup_vid_in,
    input wire [2:0]  ingress_admit_out,
    input wire [2:0]  egress_member_out,
    input wire [2:0]  egress_untag_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    a_upper_bits_zero: assert property (reg_rdata_out[31:18] == 14'h0000)
        else $error("read data upper bits set");
    a_reset_clears_data: assert property ($past(sys_rst_in) |-> reg_rdata_out == 32'h0)
        else $error("read data not cleared by reset");
    a_data_holds: assert property (!$past(reg_rd_in) && !$past(sys_rst_in) |-> $stable(reg_rdata_out))
        else $error("read data changed without a read");
    a_null_vid_off: assert property ($past(lookup_vid_in) == 12'h000 |->
        ingress_admit_out == 3'h0 && egress_member_out == 3'h0 && egress_untag_out == 3'h0)
        else $error("null vid matched an entry");
    a_member_admits: assert property ((egress_member_out & ~ingress_admit_out) == 3'h0)
        else $error("member port not admitted");
    a_status_reserved: assert property ($past(reg_rd_in && reg_addr_in == 16'h1810) |->
        reg_rdata_out[31:1] == 31'h0)
        else $error("status reserved bits set");
    a_pending_seen: assert property (reg_wr_in && reg_addr_in == 16'h180b && reg_wdata_in[5]
        ##[1:2] reg_rd_in && reg_addr_in == 16'h1810 |=> reg_rdata_out[0])
        else $error("pending not set after command");
    a_unmapped_zero: assert property ($past(reg_rd_in && reg_addr_in == 16'h0000) |->
        reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
endmodule // vlan_rd_monitor

/* File: tb/test_vlan_table_read_data.sv */
// bench for the vlan read-data block with a table model in the bench
// assumes the design header is on the include path
`timescale 1ns/1ps
`include "vlan_rd_defs.vh"
module test_vlan_table_read_data;
    reg mclk_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    reg  [15:0] reg_addr_in = 16'h0;
    reg  [31:0] reg_wdata_in = 32'h0;
    reg  [11:0] lookup_vid_in = 12'h0;
    wire [31:0] reg_rdata_out;
    wire [2:0]  ingress_admit_out, egress_member_out, egress_untag_out;
    reg  [17:0] tbl [0:15];
    reg  [31:0] d, e;
    reg  [2:0]  adm, mem, unt, hit;
    reg  [5:0]  typ;
    integer     err_total = 0, checks_done = 0, cyc = 0, i, j, p, s;
    vlan_table_read_data uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .lookup_vid_in(lookup_vid_in), .ingress_admit_out(ingress_admit_out),
        .egress_member_out(egress_member_out), .egress_untag_out(egress_untag_out));
    always #4 mclk_in = ~mclk_in;
    // cut a hang short well past the expected run length
    always @(posedge mclk_in)
    begin
        cyc = cyc + 1;
        if (cyc > 20000)
        begin
            err_total = err_total + 1;
            finish_test;
        end
    end
    task chk(input [31:0] seen, input [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total = err_total + 1;
        end
    endtask
    task wr(input [15:0] a, input [31:0] v);
        @(posedge mclk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, v, 1'b1};
        @(posedge mclk_in) reg_wr_in <= 1'b0;
    endtask
    // data is valid the cycle after the read edge
    task rd(input [15:0] a, output [31:0] v);
        @(posedge mclk_in) {reg_addr_in, reg_rd_in} <= {a, 1'b1};
        @(posedge mclk_in) reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask
    // issue a command and poll the pending flag under a bound
    task cmd(input [31:0] c);
        wr(`REG_VLAN_CMD, c);
        d = 32'h1;
        for (s = 0; s < 8 && d[0] !== 1'b0; s = s + 1) rd(`REG_VLAN_CMD_STS, d);
        chk(d, 32'h0);
    endtask
    task finish_test;
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        i = $urandom(67358);
        repeat (6) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        rd(`REG_VLAN_RD_DATA, d); chk(d, 32'h0);
        rd(16'h0000, d); chk(d, 32'h0);
        for (i = 0; i < 16; i = i + 1)
        begin
            e = $urandom;
            if (e[11:0] == 12'h0 || e[11:0] == 12'h3ff) e[11:0] = i[11:0] + 12'h001;
            tbl[i] = e[17:0];
            wr(`REG_VLAN_WR_DATA, e);
            cmd(i);
        end
        for (i = 15; i >= 0; i = i - 1)
        begin
            cmd(32'h20 | i);
            rd(`REG_VLAN_RD_DATA, d); chk(d, {14'h0, tbl[i]});
            wr(`REG_VLAN_RD_DATA, 32'hffffffff);
            rd(`REG_VLAN_RD_DATA, d); chk(d, {14'h0, tbl[i]});
        end
        wr(`REG_VLAN_WR_DATA, 32'h5); cmd(32'h11); cmd(32'h31);
        rd(`REG_VLAN_RD_DATA, d); chk(d, 32'h5);
        cmd(32'h3f); rd(`REG_VLAN_RD_DATA, d); chk(d, 32'h0);
        wr(`REG_VLAN_CMD, 32'h20); cmd(32'h21);
        rd(`REG_VLAN_RD_DATA, d); chk(d, {14'h0, tbl[0]});
        for (i = 0; i < 8; i = i + 1)
        begin
            e = $urandom; {adm, typ} = e[8:0];
            wr(`REG_ADMIT_NONMEM, {29'h0, adm}); wr(`REG_EGRESS_TYPE, {26'h0, typ});
            @(posedge mclk_in) lookup_vid_in <= (i == 7) ? 12'h0 : tbl[$urandom % 16][11:0];
            repeat (2) @(posedge mclk_in);
            #1 {hit, mem, unt} = 9'h0;
            for (j = 0; j < 16; j = j + 1)
                for (p = 0; p < 3; p = p + 1)
                    if (lookup_vid_in != 0 && tbl[j][11:0] == lookup_vid_in)
                    begin
                        hit[p] = 1'b1;
                        mem[p] = mem[p] | tbl[j][13 + 2 * p];
                        unt[p] = unt[p] | (tbl[j][12 + 2 * p] & (typ[2 * p +: 2] == 2'h3));
                    end
            chk({29'h0, ingress_admit_out}, {29'h0, hit & (mem | adm)});
            chk({29'h0, egress_member_out}, {29'h0, mem});
            chk({29'h0, egress_untag_out}, {29'h0, unt});
        end
        finish_test;
    end
endmodule // test_vlan_table_read_data
bind vlan_table_read_data vlan_rd_monitor mon (.*);
